// file: rtl/pafb_map.svh
// Purpose: Register offsets, field positions, reset values and timing for the pin mux block
// Assumes: Included by its bare name from the pafb design files
// Notes: Register byte address = port index * 0x10 + field offset
`ifndef PAFB_MAP_SVH
`define PAFB_MAP_SVH
// Port indices
`define PAFB_NPORT 8
`define PAFB_P2 3'd0
`define PAFB_P3 3'd1
`define PAFB_P4 3'd2
`define PAFB_CM 3'd3
`define PAFB_CT 3'd4
`define PAFB_CS 3'd5
`define PAFB_DH 3'd6
`define PAFB_DL 3'd7
// Field offsets inside a port slot, plus the P2OUT byte address
`define PAFB_OFS_FSEL 4'h0
`define PAFB_OFS_DIR 4'h4
`define PAFB_OFS_DOUT 4'h8
`define PAFB_OFS_PIN 4'hC
`define PAFB_OFS_P2OUT 8'h80
// Reset values
`define PAFB_RST_FSEL 16'h0000
`define PAFB_RST_DIR 16'h0000
`define PAFB_RST_DOUT 16'h0000
`define PAFB_RST_P2OUT 5'h00
// Port CM bit positions
`define PAFB_CM_WAIT 0
`define PAFB_CM_HOLDRQ 3
// Clock output half period in clk_i cycles
`define PAFB_CLK_HALF 1
// Bus answers
`define PAFB_RESP_OKAY 2'b00
`define PAFB_RESP_DECERR 2'b11
`endif

// file: rtl/pafb_pkg.sv
// Purpose: Types shared by the pin mux block and its users
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Constants live in pafb_map.svh
package pafb_pkg;
    typedef enum logic [2:0] {
        idle_bus_state = 3'b000,
        address_bus_state = 3'b001,
        second_bus_state = 3'b010,
        wait_bus_state = 3'b011,
        final_bus_state = 3'b100,
        hold_bus_state = 3'b101
    } pafb_bus_state_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic write;
        logic [2:0] block;
    } pafb_req_t;

    typedef struct packed {
        logic [3:0] timer2_pulse_out;
        logic timer3_pulse_out;
        logic [2:0] uart_tx_out;
        logic [1:0] uart_serial_clock_out;
        logic [1:0] uart_serial_clock_oe;
        logic [1:0] clocked_serial_out;
        logic [1:0] clocked_serial_clock_out;
        logic [1:0] clocked_serial_clock_oe;
        logic can_tx_out;
    } pafb_periph_out_t;

    typedef struct packed {
        logic [5:0] irq_capture_in_t2;
        logic [1:0] irq_capture_in_t3;
        logic [1:0] timer_ext_count_in;
        logic [1:0] timer_ext_clear_in;
        logic [2:0] uart_rx_in;
        logic [1:0] uart_serial_clock_in;
        logic [1:0] clocked_serial_in;
        logic [1:0] clocked_serial_clock_in;
        logic can_rx_in;
    } pafb_periph_in_t;
endpackage

// file: rtl/pafb_top.sv
// Purpose: Port/alternate-function pin mux with external memory bus controller
// Assumes: All pad inputs asynchronous; AXI4-Lite on clk_i
// Notes: Every pad output is registered once more after the mux
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pafb_map.svh"

module pafb_top
    import pafb_pkg::*;
#(
    parameter int NP = `PAFB_NPORT,
    parameter int CLK_HALF = `PAFB_CLK_HALF
) (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Async reset, high
    input wire logic [31:0] s_axi_awaddr_i, // Write address
    input wire logic s_axi_awvalid_i, // Write address valid
    output logic s_axi_awready_o, // Write address ready
    input wire logic [31:0] s_axi_wdata_i, // Write data
    input wire logic [3:0] s_axi_wstrb_i, // Write strobes
    input wire logic s_axi_wvalid_i, // Write data valid
    output logic s_axi_wready_o, // Write data ready
    output logic [1:0] s_axi_bresp_o, // Write response
    output logic s_axi_bvalid_o, // Write response valid
    input wire logic s_axi_bready_i, // Write response ready
    input wire logic [31:0] s_axi_araddr_i, // Read address
    input wire logic s_axi_arvalid_i, // Read address valid
    output logic s_axi_arready_o, // Read address ready
    output logic [31:0] s_axi_rdata_o, // Read data
    output logic [1:0] s_axi_rresp_o, // Read response
    output logic s_axi_rvalid_o, // Read valid
    input wire logic s_axi_rready_i, // Read ready
    input wire logic [NP-1:0][15:0] pad_in_i, // Pad levels
    output logic [NP-1:0][15:0] pad_out_o, // Pad drive values
    output logic [NP-1:0][15:0] pad_oe_o, // Pad enables, high drives
    input wire pafb_periph_out_t periph_out_i, // Peripheral outputs
    output var pafb_periph_in_t periph_in_o, // Peripheral inputs
    input wire logic req_valid_i, // Bus request valid
    input wire pafb_req_t req_i, // Bus request
    output logic req_ready_o, // Bus request ready
    output logic rsp_valid_o, // Bus cycle done pulse
    output logic [15:0] rsp_rdata_o, // Read data
    output logic bus_hold_ack_o // Bus held by outside master
);

    // Valid bits per port
    function automatic logic [15:0] port_mask(input logic [2:0] p);
        case (p)
            `PAFB_CM: port_mask = 16'h001F;
            `PAFB_DL: port_mask = 16'hFFFF;
            default: port_mask = 16'h00FF;
        endcase
    endfunction

    // Mapped address check
    function automatic logic reg_ok(input logic [31:0] a);
        reg_ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00)
            && (!a[7] || a[7:0] == `PAFB_OFS_P2OUT);
    endfunction

    logic [NP-1:0][15:0] pin_s1_reg, pin_s2_reg;
    logic [NP-1:0][15:0] fsel_reg, dir_reg, dout_reg;
    logic [NP-1:0][15:0] alt_out, alt_oe, pad_out_next, pad_oe_next;
    logic [4:0] p2out_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] awaddr_reg, rdata_reg;
    logic [15:0] wdata_reg;
    logic [1:0] wstrb_reg;
    pafb_bus_state_t state_reg, state_next;
    pafb_req_t req_reg;
    pafb_periph_in_t periph_in_reg, periph_next;
    logic pend_reg, pend_next, ready_reg, rsp_valid_reg, hold_ack_reg, waitq_reg;
    logic system_clock_out_reg, lwr_n_reg, uwr_n_reg, rd_n_reg, address_latch_strobe_reg;
    logic [15:0] rdata_bus_reg;
    logic [$clog2(CLK_HALF+1)-1:0] half_cnt_reg;

    // Two-stage synchronisers for all pads
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= pad_in_i;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Write decode
    logic [2:0] w_port;
    logic [3:0] w_fld;
    logic [15:0] w_mask;
    logic do_write, w_ok;
    assign w_port = awaddr_reg[6:4];
    assign w_fld = awaddr_reg[3:0];
    assign w_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}} & port_mask(w_port);
    assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
    assign w_ok = reg_ok(awaddr_reg);

    // Read decode
    logic [2:0] r_port;
    logic [3:0] r_fld;
    logic [15:0] r_word;
    assign r_port = s_axi_araddr_i[6:4];
    assign r_fld = s_axi_araddr_i[3:0];
    assign r_word = s_axi_araddr_i[7] ? {11'h000, p2out_reg}
        : (r_fld == `PAFB_OFS_FSEL) ? fsel_reg[r_port]
        : (r_fld == `PAFB_OFS_DIR) ? dir_reg[r_port]
        : (r_fld == `PAFB_OFS_DOUT) ? dout_reg[r_port]
        : pin_s2_reg[r_port] & port_mask(r_port);

    // AXI4-Lite handshakes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `PAFB_RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= `PAFB_RESP_OKAY;
            rdata_reg <= 32'h00000000;
            awaddr_reg <= 32'h00000000;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'b00;
        end else begin
            if (s_axi_awvalid_i && awready_reg) begin
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_reg) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata_i[15:0];
                wstrb_reg <= s_axi_wstrb_i[1:0];
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= w_ok ? `PAFB_RESP_OKAY : `PAFB_RESP_DECERR;
            end
            if (bvalid_reg && s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
            if (s_axi_arvalid_i && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= reg_ok(s_axi_araddr_i) ? {16'h0000, r_word} : 32'h00000000;
                rresp_reg <= reg_ok(s_axi_araddr_i) ? `PAFB_RESP_OKAY : `PAFB_RESP_DECERR;
            end
            if (rvalid_reg && s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // Mode, direction and data registers
    // clock pin reset to port mode
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NP; i++) begin
                fsel_reg[i] <= `PAFB_RST_FSEL;
                dir_reg[i] <= `PAFB_RST_DIR;
                dout_reg[i] <= `PAFB_RST_DOUT;
            end
            p2out_reg <= `PAFB_RST_P2OUT;
        end else if (do_write && w_ok && awaddr_reg[7]) begin
            if (wstrb_reg[0]) begin
                p2out_reg <= wdata_reg[4:0];
            end
        end else if (do_write && w_ok) begin
            case (w_fld)
                `PAFB_OFS_FSEL: fsel_reg[w_port] <= (fsel_reg[w_port] & ~w_mask) | (wdata_reg & w_mask);
                `PAFB_OFS_DIR: dir_reg[w_port] <= (dir_reg[w_port] & ~w_mask) | (wdata_reg & w_mask);
                `PAFB_OFS_DOUT: dout_reg[w_port] <= (dout_reg[w_port] & ~w_mask) | (wdata_reg & w_mask);
                default: ;
            endcase
        end
    end

    // External bus control inputs
    // wait and hold request on port CM
    logic wait_act, hold_rq, tick, rise, fall, in_cycle;
    logic [15:0] ad_out, ad_oe;
    logic [7:0] cs_n;
    assign wait_act = fsel_reg[`PAFB_CM][`PAFB_CM_WAIT] && !pin_s2_reg[`PAFB_CM][`PAFB_CM_WAIT];
    assign hold_rq = fsel_reg[`PAFB_CM][`PAFB_CM_HOLDRQ] && !pin_s2_reg[`PAFB_CM][`PAFB_CM_HOLDRQ];
    assign tick = half_cnt_reg == ($clog2(CLK_HALF+1))'(CLK_HALF - 1);
    assign rise = tick && !system_clock_out_reg;
    assign fall = tick && system_clock_out_reg;
    assign in_cycle = state_reg inside {address_bus_state, second_bus_state,
        wait_bus_state, final_bus_state};

    // Bus state sequencing on clock output rising edges
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            idle_bus_state: if (rise) state_next = hold_rq ? hold_bus_state
                : pend_reg ? address_bus_state : idle_bus_state;
            address_bus_state: if (rise) state_next = second_bus_state;
            second_bus_state, wait_bus_state: if (rise) state_next = waitq_reg
                ? wait_bus_state : final_bus_state;
            final_bus_state: if (rise) state_next = idle_bus_state;
            hold_bus_state: if (rise && !hold_rq) state_next = idle_bus_state;
            default: state_next = idle_bus_state;
        endcase
    end
    assign pend_next = (pend_reg || (req_valid_i && ready_reg))
        && !(state_reg == idle_bus_state && state_next == address_bus_state);

    // Clock output divider and request latch
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            half_cnt_reg <= '0;
            system_clock_out_reg <= 1'b0;
            state_reg <= idle_bus_state;
            pend_reg <= 1'b0;
            ready_reg <= 1'b0;
            hold_ack_reg <= 1'b0;
            req_reg <= '0;
        end else begin
            half_cnt_reg <= tick ? '0 : half_cnt_reg + 1'b1;
            system_clock_out_reg <= system_clock_out_reg ^ tick;
            state_reg <= state_next;
            pend_reg <= pend_next;
            ready_reg <= state_next == idle_bus_state && !pend_next;
            hold_ack_reg <= state_next == hold_bus_state;
            if (req_valid_i && ready_reg) begin
                req_reg <= req_i;
            end
        end
    end

    // Strobes and samples on clock output falling edges
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lwr_n_reg <= 1'b1;
            uwr_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            address_latch_strobe_reg <= 1'b1;
            waitq_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rdata_bus_reg <= 16'h0000;
        end else begin
            rsp_valid_reg <= 1'b0;
            if (fall && state_reg == address_bus_state) begin
                address_latch_strobe_reg <= 1'b0;
                lwr_n_reg <= !(req_reg.write && req_reg.be[0]);
                uwr_n_reg <= !(req_reg.write && req_reg.be[1]);
                rd_n_reg <= req_reg.write;
            end
            if (fall && state_reg == second_bus_state) begin
                lwr_n_reg <= 1'b1;
                uwr_n_reg <= 1'b1;
            end
            // wait sampled in T2 and TW
            if (fall && (state_reg == second_bus_state || state_reg == wait_bus_state)) begin
                waitq_reg <= wait_act;
            end
            if (fall && state_reg == final_bus_state) begin
                address_latch_strobe_reg <= 1'b1;
                rd_n_reg <= 1'b1;
                rdata_bus_reg <= pin_s2_reg[`PAFB_DL];
                rsp_valid_reg <= 1'b1;
            end
        end
    end

    assign ad_out = state_reg == address_bus_state ? req_reg.addr[15:0] : req_reg.wdata;
    assign ad_oe = (state_reg == address_bus_state || (in_cycle && req_reg.write))
        ? 16'hFFFF : 16'h0000;
    // one select per block, idle inactive
    assign cs_n = in_cycle ? ~(8'h01 << req_reg.block) : 8'hFF;

    // Alternate function drive per port
    // timer outputs on port 2
    assign alt_out[`PAFB_P2] = {11'h000, periph_out_i.timer3_pulse_out,
        periph_out_i.timer2_pulse_out};
    assign alt_oe[`PAFB_P2] = {11'h000, p2out_reg};
    assign alt_out[`PAFB_P3] = {8'h00, periph_out_i.uart_serial_clock_out[1], 1'b0,
        periph_out_i.uart_tx_out[2], periph_out_i.uart_serial_clock_out[0], 1'b0,
        periph_out_i.uart_tx_out[1], 1'b0, periph_out_i.uart_tx_out[0]};
    assign alt_oe[`PAFB_P3] = {8'h00, periph_out_i.uart_serial_clock_oe[1], 2'b01,
        periph_out_i.uart_serial_clock_oe[0], 4'b0101};
    assign alt_out[`PAFB_P4] = {8'h00, 1'b0, periph_out_i.can_tx_out,
        periph_out_i.clocked_serial_clock_out[1], 1'b0, periph_out_i.clocked_serial_out[1],
        periph_out_i.clocked_serial_clock_out[0], 1'b0, periph_out_i.clocked_serial_out[0]};
    assign alt_oe[`PAFB_P4] = {8'h00, 2'b01, periph_out_i.clocked_serial_clock_oe[1], 2'b01,
        periph_out_i.clocked_serial_clock_oe[0], 2'b01};
    assign alt_out[`PAFB_CM] = {11'h000, 2'b00, !hold_ack_reg, system_clock_out_reg, 1'b0};
    assign alt_oe[`PAFB_CM] = {11'h000, 5'b00110};
    assign alt_out[`PAFB_CT] = {12'h000, address_latch_strobe_reg, rd_n_reg, uwr_n_reg, lwr_n_reg};
    assign alt_oe[`PAFB_CT] = {12'h000, {4{!hold_ack_reg}}};
    assign alt_out[`PAFB_CS] = {8'h00, cs_n};
    assign alt_oe[`PAFB_CS] = {8'h00, {8{!hold_ack_reg}}};
    assign alt_out[`PAFB_DH] = {8'h00, req_reg.addr[23:16]};
    assign alt_oe[`PAFB_DH] = {8'h00, {8{!hold_ack_reg}}};
    assign alt_out[`PAFB_DL] = ad_out;
    assign alt_oe[`PAFB_DL] = ad_oe & {16{!hold_ack_reg}};

    // Port or control selection per bit
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pad
            assign pad_out_next[gp] = ((alt_out[gp] & fsel_reg[gp])
                | (dout_reg[gp] & ~fsel_reg[gp])) & port_mask(3'(gp));
            assign pad_oe_next[gp] = ((alt_oe[gp] & fsel_reg[gp])
                | (dir_reg[gp] & ~fsel_reg[gp])) & port_mask(3'(gp));
        end
    endgenerate

    // Control mode inputs to peripherals
    // interrupt pins feed capture triggers
    logic [15:0] c2, c3, c4;
    assign c2 = pin_s2_reg[`PAFB_P2] & fsel_reg[`PAFB_P2];
    assign c3 = pin_s2_reg[`PAFB_P3] & fsel_reg[`PAFB_P3];
    assign c4 = pin_s2_reg[`PAFB_P4] & fsel_reg[`PAFB_P4];
    assign periph_next.irq_capture_in_t2 = c2[5:0];
    assign periph_next.irq_capture_in_t3 = c2[7:6];
    assign periph_next.timer_ext_count_in = {c2[7], c2[5]};
    assign periph_next.timer_ext_clear_in = {c2[6], c2[4]};
    assign periph_next.uart_rx_in = {c3[6], c3[3], c3[1]};
    assign periph_next.uart_serial_clock_in = {c3[7], c3[4]};
    assign periph_next.clocked_serial_in = {c4[4], c4[1]};
    assign periph_next.clocked_serial_clock_in = {c4[5], c4[2]};
    assign periph_next.can_rx_in = c4[7];

    // Output registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
            periph_in_reg <= '0;
        end else begin
            pad_out_o <= pad_out_next;
            pad_oe_o <= pad_oe_next;
            periph_in_reg <= periph_next;
        end
    end

    assign periph_in_o = periph_in_reg;
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign req_ready_o = ready_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_rdata_o = rdata_bus_reg;
    assign bus_hold_ack_o = hold_ack_reg;

endmodule // pafb_top
`default_nettype wire

// file: rtl/pafb_dummy_unused.sv
// Purpose: none
// Assumes: none
// Notes: none
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verif/pafb_props.sv
// Purpose: Port timing checks for the pin mux block
// Assumes: Clock output half period of one clk_i cycle
// Notes: Pads lag the bus state by one clk_i
`timescale 1ns/1ps
`default_nettype none
module pafb_props #(
    parameter int NP = 8,
    parameter int CLK_HALF = 1
) (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [NP-1:0][15:0] pad_out_o, // Pad values
    input wire logic [NP-1:0][15:0] pad_oe_o, // Pad enables
    input wire logic req_valid_i, // Request valid
    input wire logic req_ready_o, // Request ready
    input wire logic rsp_valid_o, // Cycle done
    input wire logic bus_hold_ack_o // Hold granted
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Strobe low for one clock-out period
    sequence low_period(s);
        !s ##1 !s ##1 s;
    endsequence
    lo_strobe_a: assert property ($fell(pad_out_o[4][0]) |-> low_period(pad_out_o[4][0]))
        else $error("low write strobe width wrong");
    hi_strobe_a: assert property ($fell(pad_out_o[4][1]) |-> low_period(pad_out_o[4][1]))
        else $error("high write strobe width wrong");
    latch_width_a: assert property ($fell(pad_out_o[4][3]) |-> (!pad_out_o[4][3]) [*4])
        else $error("address strobe too short");
    read_strobe_a: assert property (pad_oe_o[4][2] && !pad_out_o[4][2]
        |-> !req_ready_o || !$past(req_ready_o)) else $error("read strobe outside cycle");
    hold_float_a: assert property (bus_hold_ack_o && $past(bus_hold_ack_o)
        |-> pad_oe_o[7] == 16'h0000 && pad_oe_o[4][3:0] == 4'h0 && pad_oe_o[5][7:0] == 8'h00)
        else $error("bus driven during hold");
    hold_refuse_a: assert property (bus_hold_ack_o |-> !req_ready_o)
        else $error("request taken during hold");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    req_take_a: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
        else $error("second request accepted");
endmodule // pafb_props
bind pafb_top pafb_props #(.NP(NP), .CLK_HALF(CLK_HALF)) props_u (.*);
`default_nettype wire

// file: verif/pafb_ext_mem.sv
// Purpose: External memory on the multiplexed bus
// Assumes: Sixteen words, low address bits 4:1
// Notes: Data lines show the inverse value while the read strobe is high
`timescale 1ns/1ps
`default_nettype none
module pafb_ext_mem (
    input wire logic clk_i, // Clock
    input wire logic [7:0][15:0] pad_out_i, // Device pad values
    input wire logic slow_i, // Stretch bus cycles with waits
    output logic [15:0] dl_o, // Data lines to device
    output logic wait_n_o // Wait request, low active
);
    logic [15:0] mem [16];
    logic [3:0] adr = 4'h0;
    logic [3:0] ct_q = 4'hF;
    int wcnt = 0;
    // address taken as latch strobe falls; bytes stored at strobe end
    always @(posedge clk_i) begin
        ct_q <= pad_out_i[4][3:0];
        if (ct_q[3] && !pad_out_i[4][3]) adr <= pad_out_i[7][4:1];
        if (!ct_q[0] && pad_out_i[4][0]) mem[adr][7:0] <= pad_out_i[7][7:0];
        if (!ct_q[1] && pad_out_i[4][1]) mem[adr][15:8] <= pad_out_i[7][15:8];
        wcnt <= (&pad_out_i[5][7:0]) ? 0 : wcnt + 1;
    end
    // wait held from idle until four select-low cycles; data only while read low
    assign wait_n_o = !(slow_i && wcnt < 4);
    assign dl_o = pad_out_i[4][2] ? ~mem[adr] : mem[adr];
endmodule // pafb_ext_mem
`default_nettype wire

// file: verif/pafb_top_test.sv
// Purpose: Self-checking bench for the pin mux block
// Assumes: Memory model on the external bus
// Notes: Expected results queue up, a monitor compares
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module pafb_top_test;
    import pafb_pkg::*;
    logic clk = 0, sys_rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, rv = 0;
    logic slow = 0, awready, wready, bvalid, arready, rvalid, req_ready, rsp_valid, hold_ack;
    logic wait_n;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v;
    logic [1:0] bresp, rresp;
    logic [15:0] rsp_rdata, dl;
    logic [7:0][15:0] pad_tb = 128'h0008_0000_0000_0000, pad_in, pad_out, pad_oe;
    logic [23:0] fs [5] = '{24'h30000F, 24'h40000F, 24'h5000FF, 24'h6000FF, 24'h70FFFF};
    pafb_periph_out_t pout = 0;
    pafb_periph_in_t pin;
    pafb_req_t req = 0;
    logic [33:0] re, rq [$];
    logic [16:0] bq [$];
    int n_errors = 0, n_checks = 0, cyc = 0;
    pafb_top dut_u (.clk_i(clk), .sys_rst_i(sys_rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .periph_out_i(pout), .periph_in_o(pin), .req_valid_i(rv), .req_i(req),
        .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
        .bus_hold_ack_o(hold_ack));
    pafb_ext_mem mem_u (.clk_i(clk), .pad_out_i(pad_out), .slow_i(slow), .dl_o(dl),
        .wait_n_o(wait_n));
    // Clock and pad levels
    always #12.5 clk = ~clk;
    always_comb begin
        pad_in = pad_tb;
        pad_in[7] = dl;
        pad_in[3][0] = wait_n;
    end
    // Monitor takes the oldest note per result
    always @(posedge clk) begin
        cyc <= (&pad_out[5][7:0]) ? 0 : cyc + 1; // Select-low cycles so far
        if (bvalid && bready) `CHK(bresp, 2'h0)
        if (rvalid && rready) begin
            re = rq.pop_front();
            `CHK({rresp, rdata}, re)
        end
        if (rsp_valid) `CHK(cyc, slow ? 10 : 4)
        if (rsp_valid && bq[0][16]) `CHK(rsp_rdata, bq[0][15:0])
        if (rsp_valid) void'(bq.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
        end while (!bvalid);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        araddr <= {24'h0, a};
        arv <= 1;
        rready <= 1;
        rq.push_back(e);
        do begin
            @(posedge clk);
            if (arready) arv <= 0;
        end while (!rvalid);
        rready <= 0;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: {19'h0, a, 1'h0}, wdata: d, be: 2'h3, write: w, block: a[2:0]};
        rv <= 1;
        bq.push_back({!w, d});
        do @(posedge clk); while (!req_ready);
        rv <= 0;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        #(25 * 20000);
        n_errors++;
        end_sim;
    end
    initial begin
        void'($urandom(3804));
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        repeat (2) @(posedge clk);
        `CHK(pad_oe, 128'h0)
        rd(8'h30, 34'h0);
        rd(8'h90, {2'h3, 32'h0});
        // Port mode direction and data
        v = $urandom;
        wr(8'h04, {24'h0, v[7:0]});
        wr(8'h08, {16'h0, v[31:16]});
        rd(8'h04, {26'h0, v[7:0]});
        repeat (3) @(posedge clk);
        `CHK(pad_oe[0][7:0], v[7:0])
        `CHK(pad_out[0][7:0], v[23:16])
        // Alternate functions on ports 2, 3 and 4
        wr(8'h00, 32'hFF);
        wr(8'h80, 32'h1F);
        wr(8'h10, 32'hFF);
        wr(8'h20, 32'hFF);
        v = $urandom;
        pout <= v[18:0];
        pad_tb[0] <= {8'h0, v[31:24]};
        pad_tb[1] <= {8'h0, v[26:19]};
        pad_tb[2] <= {8'h0, v[15:8]};
        repeat (5) @(posedge clk);
        `CHK(pad_out[0][4:0], {pout.timer3_pulse_out, pout.timer2_pulse_out})
        `CHK(pin.irq_capture_in_t2, pad_tb[0][5:0])
        `CHK(pin.timer_ext_count_in, {pad_tb[0][7], pad_tb[0][5]})
        `CHK(pad_out[1][0], pout.uart_tx_out[0])
        `CHK(pad_oe[1][0], 1'h1)
        `CHK(pin.uart_rx_in, {pad_tb[1][6], pad_tb[1][3], pad_tb[1][1]})
        `CHK(pad_out[2][6], pout.can_tx_out)
        `CHK(pin.clocked_serial_in, {pad_tb[2][4], pad_tb[2][1]})
        // External bus pins to the controller
        foreach (fs[i]) wr(fs[i][23:16], {16'h0, fs[i][15:0]});
        `CHK(pad_oe[3][1], 1'h1)
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            while (!req_ready) @(posedge clk);
            slow <= i[1];
            v = $urandom;
            bus(1'h1, v[3:0], v[31:16]);
            bus(1'h0, v[3:0], v[31:16]);
        end
        // Hold raised behind a running read
        bus(1'h0, v[3:0], v[31:16]);
        pad_tb[3][3] <= 0;
        while (!hold_ack) @(posedge clk);
        @(posedge clk);
        `CHK(bq.size(), 0)
        `CHK(pad_oe[7], 16'h0)
        `CHK(pad_out[3][2], 1'h0)
        pad_tb[3][3] <= 1;
        while (hold_ack) @(posedge clk);
        bus(1'h0, v[3:0], v[31:16]);
        while (bq.size() > 0) @(posedge clk);
        end_sim;
    end
endmodule // pafb_top_test
`default_nettype wire
